// file: rtl/facs_pkg.sv
package facs_pkg;
  // apb register byte offsets
  localparam logic [11:0] OFF_MCR    = 12'h000;
  localparam logic [11:0] OFF_BAH    = 12'h004;
  localparam logic [11:0] OFF_BAL    = 12'h008;
  localparam logic [11:0] OFF_CTL    = 12'h00c;
  localparam logic [11:0] OFF_BS0    = 12'h010;
  localparam logic [11:0] OFF_SHADOW = 12'h020;
  localparam logic [11:0] OFF_STAT   = 12'h024;
  // module config fields
  localparam int MCR_STOP = 15;
  localparam int MCR_BOOT = 12;
  localparam int MCR_LOCK = 11;
  localparam int MCR_ASPC = 9;
  localparam int MCR_WAIT = 4;
  // control fields
  localparam int CTL_VERIFY_XOR_ENABLE = 3;
  localparam int CTL_ERASE_SELECT = 2;
  localparam int CTL_LAT  = 1;
  localparam int CTL_HV_PULSE_ENABLE = 0;
  // shadow word select (index in shadow store)
  localparam logic [1:0] SH_MCR = 2'h0;
  localparam logic [1:0] SH_BAH = 2'h1;
  localparam logic [1:0] SH_BAL = 2'h2;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [15:0] ZERO_WORD   = 16'h0000;
  // bus function codes
  localparam logic [2:0] FC_SUP_DATA = 3'h5;
  localparam logic [2:0] FC_SUP_PROG = 3'h6;
  localparam logic [2:0] FC_USR_DATA = 3'h1;
  localparam logic [2:0] FC_USR_PROG = 3'h2;
  localparam logic [1:0] BOOT_LAST = 2'h3;
  localparam int unsigned BASE_ALIGN_BITS = 11;
  typedef enum logic [1:0] {FACS_IDLE, FACS_WAIT, FACS_SECOND, FACS_DONE} facs_acc_t;
endpackage

// file: rtl/facs_array_mem.sv
`timescale 1ns/100ps
`default_nettype none
module facs_array_mem #(
  parameter int AW = 10
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // access
  input  wire logic [AW-1:0] addr,
  input  wire logic          progEn,
  input  wire logic [15:0]   progData,
  input  wire logic [1:0]    progLanes,
  input  wire logic          eraseEn,
  output logic      [15:0]   rdData
);
  import facs_pkg::*;
  logic [15:0] mem [2**AW];
  logic [15:0] old;
  assign old = mem[addr];
  // nonvolatile cells power up erased, not cleared by reset
  initial begin
    for (int i = 0; i < 2**AW; i++) begin
      mem[i] = ERASED_WORD;
    end
  end
  // one process owns the cells: erase wins over program
  always @(posedge clk) begin
    if (eraseEn) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem[i] <= ERASED_WORD;
      end
    end else if (progEn) begin
      // program clears only
      mem[addr] <= old & ~({{8{progLanes[1]}}, {8{progLanes[0]}}} & ~progData);
    end
    rdData <= old;
  end
endmodule
`default_nettype wire

// file: rtl/facs_sequencer.sv
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module facs_sequencer #(
  parameter int AW = 10
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // strap
  input  wire logic        sleepStrapBusPin,
  // apb control block
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [2:0]  pprot,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // internal module bus
  input  wire logic        busReq,
  input  wire logic        busWrite,
  input  wire logic [23:0] busAddr,
  input  wire logic [2:0]  busFc,
  input  wire logic [1:0]  busLanes,
  input  wire logic        busLong,
  input  wire logic [15:0] busWdata,
  output logic             busAck,
  output logic      [31:0] busRdata,
  // high voltage
  output logic             hvPulseOn
);
  import facs_pkg::*;
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] mcr_r, bah_r, bal_r, ctl_r;
  logic [15:0] boot_r [4];
  logic [15:0] shadow_r [3];
  logic        latched_r, bootDone_r, rstSeen_r;
  logic [AW-1:0] latAddr_r;
  logic [15:0] latData_r;
  logic [1:0]  latLanes_r;
  logic [1:0]  latSh_r;
  logic        latShadow_r;
  facs_acc_t   st_r;
  logic [1:0]  waitCnt_r;
  logic        pready_r, pslverr_r, busAck_r, hvPulseOn_r, hvPrev_r;
  logic [31:0] prdata_r, busRdata_r;
  logic [15:0] lowWord_r;
  logic        secondHalf_r;
  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic isSup(input logic [2:0] p);
    return p[0];
  endfunction
  wire        stopBit  = mcr_r[MCR_STOP];
  wire        hv_pulse_enable     = ctl_r[CTL_HV_PULSE_ENABLE];
  wire        lat      = ctl_r[CTL_LAT];
  wire        erase_select     = ctl_r[CTL_ERASE_SELECT];
  wire        verify_xor_enable     = ctl_r[CTL_VERIFY_XOR_ENABLE];
  wire [1:0]  aspc     = mcr_r[MCR_ASPC+:2];
  wire [1:0]  waitSel  = mcr_r[MCR_WAIT+:2];
  wire [12:0] baseHi   = {bah_r[7:0], bal_r[15:11]};
  wire        inBlock  = busAddr[23:BASE_ALIGN_BITS] == baseHi;
  // array smaller than base block leaves a hole
  wire        inArray  = inBlock && (busAddr[BASE_ALIGN_BITS-1:0] >> (AW + 1)) == '0;
  wire        progSp   = busFc == FC_SUP_PROG || busFc == FC_USR_PROG;
  wire        dataSp   = busFc == FC_SUP_DATA || busFc == FC_USR_DATA;
  wire        spaceOk  = aspc[1] ? progSp : (progSp || dataSp);
  wire        supOk    = aspc[0] || busFc[2];
  wire        bootHit  = !stopBit && !mcr_r[MCR_BOOT] && !bootDone_r && progSp
                         && busAddr[23:3] == '0;
  wire        arrHit   = !stopBit && inArray && spaceOk && supOk;
  wire [AW-1:0] wAddr  = busAddr[AW:1];
  wire        apbAcc   = psel && penable && pready_r;
  wire        apbSup   = isSup(pprot) && !pprot[2];
  wire        apbWr    = apbAcc && pwrite && apbSup;
  wire [15:0] memQ;
  // ----------------------------------------
  // array
  // ----------------------------------------
  // one array update per pulse (one word programmed or every cell erased), on its leading edge
  wire memProg = hvPulseOn_r && !erase_select && !latShadow_r && !hvPrev_r;
  wire memErase = hvPulseOn_r && erase_select && !hvPrev_r;
  facs_array_mem #(.AW(AW)) uMem (
    .clk       (clk),
    .reset_n   (reset_n),
    .addr      (memProg ? latAddr_r : (secondHalf_r ? wAddr + AW'(1) : wAddr)),
    .progEn    (memProg),
    .progData  (latData_r),
    .progLanes (latLanes_r),
    .eraseEn   (memErase),
    .rdData    (memQ)
  );
  // ----------------------------------------
  // reset load from shadow and strap
  // ----------------------------------------
  // stop from shadow or low strap
  wire stopLoad = shadow_r[SH_MCR][MCR_STOP] || !sleepStrapBusPin;
  wire [15:0] ctlWr = pwdata[15:0];
  wire [15:0] ctlNxt = hv_pulse_enable ? {ctl_r[15:1], ctlWr[CTL_HV_PULSE_ENABLE]}
                           : {ctlWr[15:1], ctlWr[CTL_HV_PULSE_ENABLE] && lat && latched_r};
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rstSeen_r <= 1'b1;
      ctl_r <= ZERO_WORD;
      latched_r <= 1'b0;
      bootDone_r <= 1'b0;
      hvPulseOn_r <= 1'b0;
      hvPrev_r <= 1'b0;
    end else begin
      rstSeen_r <= 1'b0;
      hvPrev_r <= hvPulseOn_r;
      hvPulseOn_r <= hv_pulse_enable && !stopBit;
      if (apbWr && paddr == OFF_CTL) begin
        ctl_r <= ctlNxt;
      end
      if (!lat) begin
        latched_r <= 1'b0;
      end
      // boot window closes when last word is requested, so that fetch reads the array
      if (busReq && bootHit && busAddr[2:1] == BOOT_LAST) begin
        bootDone_r <= 1'b1;
      end
      if (busReq && busWrite && lat && !hv_pulse_enable && !latched_r && inArray && !stopBit) begin
        latched_r <= 1'b1;
      end
      if (apbWr && lat && !hv_pulse_enable && !latched_r && paddr != OFF_CTL) begin
        latched_r <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rstSeen_r) begin
      mcr_r <= shadow_r[SH_MCR];
      mcr_r[MCR_STOP] <= stopLoad;
      bah_r <= shadow_r[SH_BAH];
      bal_r <= shadow_r[SH_BAL];
    end else if (apbWr && (!mcr_r[MCR_LOCK] || stopBit) && !lat) begin
      if (paddr == OFF_MCR) mcr_r <= ctlWr;
      if (paddr == OFF_BAH) bah_r <= ctlWr;
      if (paddr == OFF_BAL) bal_r <= ctlWr;
    end
  end
  always_ff @(posedge clk) begin
    if (busReq && busWrite && lat && !hv_pulse_enable && !latched_r && inArray && !stopBit) begin
      latAddr_r <= wAddr;
      latData_r <= busWdata;
      latLanes_r <= busLanes;
      latShadow_r <= 1'b0;
    end else if (apbWr && lat && !hv_pulse_enable && !latched_r && paddr != OFF_CTL) begin
      latData_r <= ctlWr;
      latLanes_r <= 2'h3;
      latShadow_r <= 1'b1;
      latSh_r <= paddr[3:2];
    end
  end
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gShadow
      always @(posedge clk) begin
        if (memErase) begin
          shadow_r[g] <= ERASED_WORD;
        end else if (hvPulseOn_r && !erase_select && latShadow_r && latSh_r == 2'(g)) begin
          shadow_r[g] <= shadow_r[g] & latData_r;
        end
      end
    end
    for (g = 0; g < 4; g++) begin : gBoot
      always @(posedge clk) begin
        if (memErase) begin
          boot_r[g] <= ERASED_WORD;
        end
      end
    end
  endgenerate
  // shadow store powers up erased, so a blank module wakes asleep
  initial begin
    for (int i = 0; i < 3; i++) begin
      shadow_r[i] = ERASED_WORD;
    end
    for (int i = 0; i < 4; i++) begin
      boot_r[i] = ERASED_WORD;
    end
  end
  // ----------------------------------------
  // bus access timing
  // ----------------------------------------
  // verify xor
  wire [15:0] rdWord = (lat && verify_xor_enable && !erase_select) ? (memQ ^ latData_r) : memQ;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= FACS_IDLE;
      busAck_r <= 1'b0;
      busRdata_r <= 32'h0;
      waitCnt_r <= 2'h0;
      secondHalf_r <= 1'b0;
    end else begin
      busAck_r <= 1'b0;
      unique case (st_r)
        FACS_IDLE: begin
          if (busReq && !busWrite && !hv_pulse_enable && (arrHit || bootHit)) begin
            st_r <= FACS_WAIT;
            waitCnt_r <= waitSel;
          end
        end
        FACS_WAIT: begin
          if (waitCnt_r != 2'h0) begin
            waitCnt_r <= waitCnt_r - 2'h1;
          end else if (busLong && !secondHalf_r) begin
            lowWord_r <= bootHit ? boot_r[busAddr[2:1]] : rdWord;
            secondHalf_r <= 1'b1;
            st_r <= FACS_SECOND;
          end else begin
            busAck_r <= 1'b1;
            busRdata_r <= {16'h0, bootHit ? boot_r[busAddr[2:1]] : rdWord};
            st_r <= FACS_DONE;
          end
        end
        FACS_SECOND: begin
          busAck_r <= 1'b1;
          busRdata_r <= {lowWord_r, rdWord};
          secondHalf_r <= 1'b0;
          st_r <= FACS_DONE;
        end
        FACS_DONE: begin
          st_r <= busReq ? FACS_DONE : FACS_IDLE;
        end
      endcase
    end
  end
  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  wire [15:0] apbSel = paddr == OFF_MCR ? mcr_r :
                       paddr == OFF_BAH ? bah_r :
                       paddr == OFF_BAL ? bal_r :
                       paddr == OFF_CTL ? ctl_r :
                       paddr[11:4] == OFF_BS0[11:4] ? boot_r[paddr[3:2]] :
                       paddr == OFF_STAT ? {14'h0, bootDone_r, latched_r} : ZERO_WORD;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= psel && !penable;
      pslverr_r <= psel && !penable && !apbSup;
      prdata_r <= {16'h0, apbSel};
    end
  end
  assign pready   = pready_r;
  assign prdata   = prdata_r;
  assign pslverr  = pslverr_r;
  assign busAck   = busAck_r;
  assign busRdata = busRdata_r;
  assign hvPulseOn = hvPulseOn_r;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_hv_pulse_enable_gate: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(hv_pulse_enable) |-> $past(lat) && $past(latched_r)) else $error("pulse without latch");
  a_pulse_follow: assert property (@(posedge clk) disable iff (!reset_n)
    hv_pulse_enable && !stopBit |=> hvPulseOn) else $error("pulse not applied");
  a_freeze_bits: assert property (@(posedge clk) disable iff (!reset_n)
    hv_pulse_enable && $past(hv_pulse_enable) |-> $stable(ctl_r[3:1])) else $error("bits changed in pulse");
  a_sleep_ignore: assert property (@(posedge clk) disable iff (!reset_n)
    st_r == FACS_IDLE && stopBit |=> st_r == FACS_IDLE) else $error("asleep but answered");
  a_pulse_stop: assert property (@(posedge clk) disable iff (!reset_n)
    !hv_pulse_enable |=> !hvPulseOn) else $error("pulse not stopped");
  a_hole_ignore: assert property (@(posedge clk) disable iff (!reset_n)
    st_r == FACS_IDLE && !arrHit && !bootHit |=> st_r == FACS_IDLE) else $error("hole answered");
  a_ack_single: assert property (@(posedge clk) disable iff (!reset_n)
    busAck |=> !busAck) else $error("ack longer than one cycle");
endmodule
`default_nettype wire

// file: tb/facs_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module facs_cpu_model import facs_pkg::*; (
  // clock
  input  wire logic        clk,
  // module bus requests
  output logic             busReq,
  output logic             busWrite,
  output logic      [23:0] busAddr,
  output logic      [2:0]  busFc,
  output logic      [1:0]  busLanes,
  output logic             busLong,
  output logic      [15:0] busWdata,
  // answers
  input  wire logic        busAck,
  input  wire logic [31:0] busRdata
);
  initial begin
    busReq = 1'b0;
    busWrite = 1'b0;
    busAddr = 24'h0;
    busFc = 3'h0;
    busLanes = 2'h3;
    busLong = 1'b0;
    busWdata = 16'h0;
  end
  task automatic busWr(input logic [23:0] a, input logic [15:0] d);
    @(posedge clk);
    busReq <= 1'b1;
    busWrite <= 1'b1;
    busAddr <= a;
    busFc <= FC_SUP_DATA;
    busLong <= 1'b0;
    busWdata <= d;
    // writes get no ack, so hold two cycles
    repeat (2) @(posedge clk);
    busReq <= 1'b0;
    busWrite <= 1'b0;
    busAddr <= ~a;
    busWdata <= ~d;
  endtask
  // readback; lat stays -1 if never answered
  task automatic busRd(input logic [23:0] a, input logic [2:0] fc, input logic lng,
                       output logic [31:0] d, output int lat);
    int i;
    d = 32'h0;
    lat = -1;
    @(posedge clk);
    busReq <= 1'b1;
    busAddr <= a;
    busFc <= fc;
    busLong <= lng;
    for (i = 1; i <= 12; i++) begin
      @(posedge clk);
      if (busAck === 1'b1) begin
        lat = i;
        d = busRdata;
        break;
      end
    end
    busReq <= 1'b0;
    busAddr <= ~a;
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import facs_pkg::*;
  // ----------------
  // signals
  // ----------------
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, hvPulseOn, err, strap;
  logic        busReq, busWrite, busLong, busAck;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, busRdata, rd;
  logic [2:0]  pprot, busFc;
  logic [23:0] busAddr;
  logic [1:0]  busLanes;
  logic [15:0] busWdata;
  int          fails, compares, lat0, lat;
  localparam logic [23:0] BASE = 24'h100000;
  always #25 clk = ~clk;
  facs_sequencer facs_sequencer_inst (
    .clk(clk), .reset_n(reset_n), .sleepStrapBusPin(strap),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pprot(pprot), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .busReq(busReq), .busWrite(busWrite), .busAddr(busAddr),
    .busFc(busFc), .busLanes(busLanes), .busLong(busLong), .busWdata(busWdata),
    .busAck(busAck), .busRdata(busRdata), .hvPulseOn(hvPulseOn));
  facs_cpu_model facs_cpu_model_inst (
    .clk(clk), .busReq(busReq), .busWrite(busWrite), .busAddr(busAddr),
    .busFc(busFc), .busLanes(busLanes), .busLong(busLong), .busWdata(busWdata),
    .busAck(busAck), .busRdata(busRdata));
  // ----------------
  // helpers
  // ----------------
  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [2:0] p);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pprot <= p;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      fails++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 3'h1);
  endtask
  task automatic rdb(input logic [23:0] a, input logic lng);
    facs_cpu_model_inst.busRd(a, FC_SUP_DATA, lng, rd, lat);
  endtask
  task automatic pulse(input logic e);
    @(posedge clk);
    #1;
    chk("hv pulse", {31'h0, e}, {31'h0, hvPulseOn});
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic test_sleep();
    apb(1'b0, OFF_MCR, 32'h0, 3'h1);
    chk("mcr stop", 32'h1, {31'h0, rd[MCR_STOP]});
    facs_cpu_model_inst.busRd(24'h0, FC_SUP_PROG, 1'b0, rd, lat);
    chk("boot fetch ack", 32'hffffffff, lat);
    rdb(BASE, 1'b0);
    chk("array ack asleep", 32'hffffffff, lat);
    $display("test sleep done");
  endtask
  task automatic test_access();
    wr(OFF_BAH, 32'h10);
    wr(OFF_BAL, 32'h0);
    wr(OFF_MCR, 32'h1000);
    rdb(BASE, 1'b0);
    lat0 = lat;
    chk("erased word", 32'hffff, {16'h0, rd[15:0]});
    rdb(BASE, 1'b1);
    chk("long extra cycle", 32'h1, lat - lat0);
    wr(OFF_MCR, 32'h1030);
    rdb(BASE, 1'b0);
    chk("wait states", 32'h3, lat - lat0);
    wr(OFF_MCR, 32'h1000);
    apb(1'b1, OFF_MCR, 32'h9000, 3'h0);
    chk("user slverr", 32'h1, {31'h0, err});
    apb(1'b0, OFF_MCR, 32'h0, 3'h1);
    chk("mcr kept", 32'h1000, rd);
    $display("test access done");
  endtask
  task automatic prog(input logic [23:0] a, input logic [15:0] d, input logic [15:0] e);
    wr(OFF_CTL, 32'h2);
    facs_cpu_model_inst.busWr(a, d);
    wr(OFF_CTL, 32'h3);
    pulse(1'b1);
    wr(OFF_CTL, 32'h2);
    pulse(1'b0);
    wr(OFF_CTL, 32'ha);
    rdb(a, 1'b0);
    chk("verify xor", {16'h0, d ^ e}, {16'h0, rd[15:0]});
    wr(OFF_CTL, 32'h0);
    rdb(a, 1'b0);
    chk("programmed word", {16'h0, e}, {16'h0, rd[15:0]});
  endtask
  task automatic test_program();
    prog(BASE + 24'h2, 16'h1234, 16'h1234);
    prog(BASE + 24'h2, 16'hff00, 16'h1200);
    rdb(BASE, 1'b0);
    chk("neighbour word", 32'hffff, {16'h0, rd[15:0]});
    $display("test program done");
  endtask
  task automatic test_guard();
    wr(OFF_CTL, 32'h1);
    pulse(1'b0);
    wr(OFF_CTL, 32'h2);
    facs_cpu_model_inst.busWr(BASE + 24'h4, 16'hffff);
    wr(OFF_CTL, 32'h3);
    wr(OFF_CTL, 32'h1);
    apb(1'b0, OFF_CTL, 32'h0, 3'h1);
    chk("latch frozen", 32'h3, rd & 32'hf);
    rdb(BASE + 24'h4, 1'b0);
    chk("read ignored", 32'hffffffff, lat);
    wr(OFF_CTL, 32'h2);
    wr(OFF_CTL, 32'h0);
    $display("test guard done");
  endtask
  task automatic test_erase();
    wr(OFF_CTL, 32'h6);
    facs_cpu_model_inst.busWr(BASE + 24'h6, 16'h0);
    wr(OFF_CTL, 32'h7);
    pulse(1'b1);
    wr(OFF_CTL, 32'h6);
    wr(OFF_CTL, 32'h0);
    rdb(BASE + 24'h2, 1'b0);
    chk("erased again", 32'hffff, {16'h0, rd[15:0]});
    $display("test erase done");
  endtask
  task automatic do_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic test_reset();
    wr(OFF_CTL, 32'h2);
    wr(OFF_MCR, 32'h7fff);
    wr(OFF_CTL, 32'h3);
    pulse(1'b1);
    wr(OFF_CTL, 32'h2);
    wr(OFF_CTL, 32'h0);
    apb(1'b0, OFF_MCR, 32'h0, 3'h1);
    chk("mcr untouched", 32'h1000, rd);
    do_reset();
    apb(1'b0, OFF_MCR, 32'h0, 3'h1);
    chk("shadow mcr", 32'h7fff, rd);
    strap <= 1'b0;
    do_reset();
    apb(1'b0, OFF_MCR, 32'h0, 3'h1);
    chk("strap low stop", 32'h1, {31'h0, rd[MCR_STOP]});
    $display("test reset done");
  endtask
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    strap = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pprot = 3'h0;
    fails = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    test_sleep();
    test_access();
    test_program();
    test_guard();
    test_erase();
    test_reset();
    complete_run();
  end
endmodule
`default_nettype wire
